// ==== design/daoc_regs.sv ====
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [R1] compat mode: character counter sixteen bits wide
// [R2] compat mode: wrap at 64K per map
// [R3] extended wrap: address counter nineteen bits
// [R4] extended wrap: bits 16-18 enlarge planes
// [R5] extended wrap: wrap at installed memory size
// [R6] chain4: DRAM bits 1:0 from extended 17:16
// [R7] extended high bits: host address plus offset
// [R8] double-word: DRAM bits 1:0 from counter 15:14
// [R9] start address bits 18:16 from control register
// [R10] source 0, mode 01: external video pin timing
// [R11] source 1, mode 10: internal window timing
// [R12] DAC high clear: extended mode, low bit swaps
// [R13] DAC high set: extended DAC mode off
// [R14] overlay register resets source 1, DAC 10
// [R15] shading register read/write, resets to 61h
// [R16] blanking control drives window pin from blank
// [R17] overlay reserved bits read zero, ignore writes
module daoc_regs
(
    input wire logic clk,
    input wire logic rstn,
    input wire daoc_pkg::daoc_host_req_t host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    input wire daoc_pkg::daoc_mem_ctl_t mem_ctl,
    input wire logic [15:0] start_address_low,
    input wire logic [18:0] installed_mask,
    input wire logic frame_load,
    input wire logic char_advance,
    input wire logic [1:0] overlay_mode_select,
    input wire logic feature_connector_video_input_n,
    input wire logic crtc_blank,
    output logic [18:0] character_address,
    output logic [8:0] dram_address,
    output logic overlay_active,
    output logic ext_dac_enable,
    output logic show_live_video,
    output logic overlay_window_output,
    output logic overlay_window_output_oe_n,
    output daoc_pkg::daoc_regs_t regs_out
);
    import daoc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] index;
        daoc_regs_t regs;
        logic [7:0] rdata;
        logic rvalid;
    } daoc_state_t;

    daoc_state_t st;
    daoc_state_t next_st;
    logic wr_data;
    logic rd_data;
    logic ext_wrap;

    function automatic logic [7:0] daoc_read(input daoc_regs_t r, input logic [7:0] idx);
        logic [7:0] v;
        v = UNMAPPED_READ;
        if (idx == IDX_EXT_DISPLAY_CONTROL)
            v = r.ext_display_control;
        else if (idx == IDX_VIDEO_OVERLAY_MODE)
            v = r.video_overlay_mode & OVM_WRITABLE;
        else if (idx == IDX_LCD_SHADING_CONTROL)
            v = r.lcd_shading_control;
        return v;
    endfunction : daoc_read

    // ----------------------------------------------------------------
    // indexed port
    // ----------------------------------------------------------------
    assign wr_data = host_req.wr && host_req.sel_data;
    assign rd_data = host_req.rd && host_req.sel_data;

    always_comb
    begin
        next_st = st;
        next_st.rvalid = host_req.rd;
        if (rd_data)
            next_st.rdata = daoc_read(st.regs, st.index);
        else if (host_req.rd)
            next_st.rdata = st.index;
        if (host_req.wr && !host_req.sel_data)
        begin
            next_st.index = host_req.wdata;
        end
        else if (wr_data)
        begin
            // unmapped indices swallow the write silently
            if (st.index == IDX_EXT_DISPLAY_CONTROL)
                next_st.regs.ext_display_control = host_req.wdata;
            else if (st.index == IDX_VIDEO_OVERLAY_MODE)
                next_st.regs.video_overlay_mode = host_req.wdata & OVM_WRITABLE; // R17
            else if (st.index == IDX_LCD_SHADING_CONTROL)
                next_st.regs.lcd_shading_control = host_req.wdata; // R15
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            st <= '{index: RST_INDEX,
                    regs: '{ext_display_control: RST_EXT_DISPLAY_CONTROL,
                            video_overlay_mode: RST_VIDEO_OVERLAY_MODE, // R14
                            lcd_shading_control: RST_LCD_SHADING_CONTROL}, // R15
                    rdata: 8'h00,
                    rvalid: 1'b0};
        else
            st <= next_st;
    end

    assign host_rdata = st.rdata;
    assign host_rvalid = st.rvalid;
    assign regs_out = st.regs;
    assign ext_wrap = st.regs.ext_display_control[EDC_EXT_WRAP];

    // ----------------------------------------------------------------
    // address path and overlay path
    // ----------------------------------------------------------------
    daoc_addr_gen #(.ADDR_W(19)) u_addr
    (
        .clk(clk),
        .rstn(rstn),
        .ext_wrap(ext_wrap),
        .load(frame_load),
        .advance(char_advance),
        .start_address_low(start_address_low),
        .start_hi({st.regs.ext_display_control[EDC_START_HI_LSB+1:EDC_START_HI_LSB],
                   st.regs.ext_display_control[EDC_START16]}), // R9
        .installed_mask(installed_mask),
        .mem_ctl(mem_ctl),
        .character_address(character_address),
        .dram_address(dram_address)
    );

    daoc_overlay u_ovl
    (
        .clk(clk),
        .rstn(rstn),
        .video_overlay_mode(st.regs.video_overlay_mode),
        .blank_ctrl(st.regs.ext_display_control[EDC_BLANK_CTRL]),
        .overlay_mode_select(overlay_mode_select),
        .feature_connector_video_input_n(feature_connector_video_input_n),
        .crtc_blank(crtc_blank),
        .overlay_active(overlay_active),
        .ext_dac_enable(ext_dac_enable),
        .show_live_video(show_live_video),
        .overlay_window_output(overlay_window_output),
        .overlay_window_output_oe_n(overlay_window_output_oe_n)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_compat_width;
        @(posedge clk) disable iff (!rstn)
        !ext_wrap ##1 !ext_wrap |-> character_address[18:16] == 3'h0;
    endproperty
    a_compat_width: assert property (p_compat_width) else $error("counter over 16 bits"); // R1

    property p_compat_wrap;
        @(posedge clk) disable iff (!rstn)
        (!ext_wrap && char_advance && !frame_load && character_address == 19'h0ffff)
            |=> character_address == 19'h00000;
    endproperty
    a_compat_wrap: assert property (p_compat_wrap) else $error("no 64K wrap"); // R2

    property p_start_load;
        @(posedge clk) disable iff (!rstn)
        // sampled rstn keeps the release edge, whose state is still pre-reset, out
        (rstn && ext_wrap && frame_load) |=> character_address ==
            ({$past(st.regs.ext_display_control[3:2]),
              $past(st.regs.ext_display_control[0]),
              $past(start_address_low)} & $past(installed_mask));
    endproperty
    a_start_load: assert property (p_start_load) else $error("start address load wrong"); // R9

    property p_ext_wrap_size;
        @(posedge clk) disable iff (!rstn)
        (ext_wrap && char_advance && !frame_load && character_address == installed_mask)
            |=> character_address == 19'h00000;
    endproperty
    a_ext_wrap_size: assert property (p_ext_wrap_size) else $error("no wrap at memory size"); // R5

    property p_ovm_reset;
        @(posedge clk)
        !rstn |=> regs_out.video_overlay_mode == RST_VIDEO_OVERLAY_MODE;
    endproperty
    a_ovm_reset: assert property (p_ovm_reset) else $error("overlay reset value wrong"); // R14

    property p_shade_rw;
        @(posedge clk) disable iff (!rstn)
        (rstn && wr_data && st.index == IDX_LCD_SHADING_CONTROL) ##1
            (host_req.rd && host_req.sel_data && !host_req.wr)
            |=> host_rdata == $past(host_req.wdata, 2);
    endproperty
    a_shade_rw: assert property (p_shade_rw) else $error("shading readback wrong"); // R15

    property p_ovm_reserved;
        @(posedge clk) disable iff (!rstn)
        (regs_out.video_overlay_mode & ~OVM_WRITABLE) == 8'h00;
    endproperty
    a_ovm_reserved: assert property (p_ovm_reserved) else $error("reserved bit set"); // R17

    property p_window_pin;
        @(posedge clk) disable iff (!rstn)
        rstn && st.regs.ext_display_control[EDC_BLANK_CTRL] |=>
            !overlay_window_output_oe_n && overlay_window_output == $past(crtc_blank);
    endproperty
    a_window_pin: assert property (p_window_pin) else $error("window pin not driven"); // R16

    property p_int_timing;
        @(posedge clk) disable iff (!rstn)
        (st.regs.video_overlay_mode[OVM_TIMING_SRC] && overlay_mode_select == OVSEL_INTERNAL
            && st.regs.ext_display_control[EDC_BLANK_CTRL] && rstn)
            |=> overlay_active == $past(overlay_window_output);
    endproperty
    a_int_timing: assert property (p_int_timing) else $error("internal timing not used"); // R11

    property p_dac_swap;
        @(posedge clk) disable iff (!rstn)
        rstn && !st.regs.video_overlay_mode[OVM_DAC_HI] |=> ext_dac_enable &&
            show_live_video == (overlay_active ^ $past(st.regs.video_overlay_mode[OVM_DAC_LO]));
    endproperty
    a_dac_swap: assert property (p_dac_swap) else $error("dac switching wrong"); // R12

endmodule : daoc_regs
`default_nettype wire

// ==== inc/daoc_pkg.sv ====
package daoc_pkg;

    // ----------------------------------------------------------------
    // indexed port and register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_EXT_DISPLAY_CONTROL = 8'h1b;
    localparam logic [7:0] IDX_VIDEO_OVERLAY_MODE = 8'h1d;
    localparam logic [7:0] IDX_LCD_SHADING_CONTROL = 8'h1e;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ----------------------------------------------------------------
    // reset values and masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_EXT_DISPLAY_CONTROL = 8'h00;
    localparam logic [7:0] RST_VIDEO_OVERLAY_MODE = 8'h44;
    localparam logic [7:0] RST_LCD_SHADING_CONTROL = 8'h61;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] OVM_WRITABLE = 8'h46;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int EDC_START16 = 0;
    localparam int EDC_EXT_WRAP = 1;
    localparam int EDC_START_HI_LSB = 2;
    localparam int EDC_BLANK_CTRL = 5;
    localparam int OVM_DAC_LO = 1;
    localparam int OVM_DAC_HI = 2;
    localparam int OVM_TIMING_SRC = 6;

    // ----------------------------------------------------------------
    // overlay mode select encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] OVSEL_EXTERNAL = 2'h1;
    localparam logic [1:0] OVSEL_INTERNAL = 2'h2;

    // ----------------------------------------------------------------
    // address layout
    // ----------------------------------------------------------------
    localparam logic [18:0] COMPAT_WRAP_MASK = 19'h0ffff;
    localparam int XMA_LO_BIT = 12;
    localparam int DWORD_LSB = 14;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sel_data;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } daoc_host_req_t;

    typedef struct packed {
        logic [7:0] ext_display_control;
        logic [7:0] video_overlay_mode;
        logic [7:0] lcd_shading_control;
    } daoc_regs_t;

    typedef struct packed {
        logic chain4;
        logic dword_mode;
        logic offset_sel;
        logic [6:0] graphics_offset_zero;
        logic [6:0] graphics_offset_one;
        logic [4:0] host_bus_address;
        logic [8:0] std_dram_address;
    } daoc_mem_ctl_t;

endpackage : daoc_pkg

// ==== design/daoc_addr_gen.sv ====
`timescale 1ns/1ns
`default_nettype none

module daoc_addr_gen
#(
    parameter int ADDR_W = 19
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ext_wrap,
    input wire logic load,
    input wire logic advance,
    input wire logic [15:0] start_address_low,
    input wire logic [2:0] start_hi,
    input wire logic [18:0] installed_mask,
    input wire daoc_pkg::daoc_mem_ctl_t mem_ctl,
    output logic [18:0] character_address,
    output logic [8:0] dram_address
);
    import daoc_pkg::*;

    if (ADDR_W != 19)
    begin : g_chk
        $error("daoc_addr_gen serves a 19-bit counter only");
    end

    typedef struct packed {
        logic [18:0] cnt;
        logic [8:0] ma;
    } daoc_ag_state_t;

    daoc_ag_state_t st;
    daoc_ag_state_t next_st;
    logic [18:0] mask;
    logic [6:0] xma_hi;

    always_comb
    begin
        mask = ext_wrap ? installed_mask : COMPAT_WRAP_MASK; // R1 R2 R3 R5
        xma_hi = 7'({2'h0, mem_ctl.host_bus_address}) + (mem_ctl.offset_sel ?
            mem_ctl.graphics_offset_one : mem_ctl.graphics_offset_zero); // R7
        next_st = st;
        // a held count is masked too, so dropping the wrap enable clears stale high bits
        next_st.cnt = st.cnt & mask; // R1
        if (load)
        begin
            next_st.cnt = {start_hi, start_address_low} & mask; // R9 R4
        end
        else if (advance)
        begin
            next_st.cnt = 19'(st.cnt + 19'h00001) & mask; // R5
        end
        if (ext_wrap && mem_ctl.dword_mode)
        begin
            next_st.ma = {xma_hi, st.cnt[DWORD_LSB+1:DWORD_LSB]}; // R8
        end
        else if (ext_wrap && mem_ctl.chain4)
        begin
            next_st.ma = {xma_hi, xma_hi[17-XMA_LO_BIT], xma_hi[16-XMA_LO_BIT]}; // R6
        end
        else
        begin
            next_st.ma = mem_ctl.std_dram_address;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            st <= '0;
        else
            st <= next_st;
    end

    assign character_address = st.cnt;
    assign dram_address = st.ma;

    property p_chain4_map;
        @(posedge clk) disable iff (!rstn)
        // sampled rstn keeps the release edge, whose state is still pre-reset, out
        (rstn && ext_wrap && mem_ctl.chain4 && !mem_ctl.dword_mode) |=>
            dram_address[1:0] == $past(xma_hi[5:4]) && dram_address[8:2] == $past(xma_hi);
    endproperty
    a_chain4_map: assert property (p_chain4_map) else $error("chain4 mapping wrong"); // R6

    property p_dword_map;
        @(posedge clk) disable iff (!rstn)
        (rstn && ext_wrap && mem_ctl.dword_mode)
            |=> dram_address[1:0] == $past(st.cnt[15:14]);
    endproperty
    a_dword_map: assert property (p_dword_map) else $error("dword mapping wrong"); // R8

endmodule : daoc_addr_gen
`default_nettype wire

// ==== design/daoc_overlay.sv ====
`timescale 1ns/1ns
`default_nettype none

module daoc_overlay
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] video_overlay_mode,
    input wire logic blank_ctrl,
    input wire logic [1:0] overlay_mode_select,
    input wire logic feature_connector_video_input_n,
    input wire logic crtc_blank,
    output logic overlay_active,
    output logic ext_dac_enable,
    output logic show_live_video,
    output logic overlay_window_output,
    output logic overlay_window_output_oe_n
);
    import daoc_pkg::*;

    typedef struct packed {
        logic active;
        logic dac_en;
        logic live;
        logic win;
        logic oe_n;
    } daoc_ov_state_t;

    daoc_ov_state_t st;
    daoc_ov_state_t next_st;
    logic timing;

    always_comb
    begin
        // internal window is the pin's own driven value, so no loopback wire is needed
        if (!video_overlay_mode[OVM_TIMING_SRC] && overlay_mode_select == OVSEL_EXTERNAL)
            timing = !feature_connector_video_input_n; // R10
        else if (video_overlay_mode[OVM_TIMING_SRC] && overlay_mode_select == OVSEL_INTERNAL)
            timing = blank_ctrl && st.win; // R11
        else
            timing = 1'b0;
        next_st.active = timing;
        next_st.dac_en = !video_overlay_mode[OVM_DAC_HI]; // R12 R13
        next_st.live = !video_overlay_mode[OVM_DAC_HI]
            && (timing ^ video_overlay_mode[OVM_DAC_LO]); // R12
        next_st.win = blank_ctrl ? crtc_blank : 1'b0; // R16
        next_st.oe_n = !blank_ctrl; // R16
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            st <= '{active: 1'b0, dac_en: 1'b0, live: 1'b0, win: 1'b0, oe_n: 1'b1};
        else
            st <= next_st;
    end

    assign overlay_active = st.active;
    assign ext_dac_enable = st.dac_en;
    assign show_live_video = st.live;
    assign overlay_window_output = st.win;
    assign overlay_window_output_oe_n = st.oe_n;

    property p_dac_off;
        @(posedge clk) disable iff (!rstn)
        video_overlay_mode[OVM_DAC_HI] |=> !ext_dac_enable && !show_live_video;
    endproperty
    a_dac_off: assert property (p_dac_off) else $error("dac mode not disabled"); // R13

    property p_ext_timing;
        @(posedge clk) disable iff (!rstn)
        // sampled rstn keeps the release edge, whose state is still pre-reset, out
        (rstn && !video_overlay_mode[OVM_TIMING_SRC] && overlay_mode_select == OVSEL_EXTERNAL)
            |=> overlay_active == !$past(feature_connector_video_input_n);
    endproperty
    a_ext_timing: assert property (p_ext_timing) else $error("external timing not used"); // R10

endmodule : daoc_overlay
`default_nettype wire

// ==== verif/daoc_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module daoc_host_model
(
    input wire logic clk,
    output var daoc_pkg::daoc_host_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid
);
    import daoc_pkg::*;

    // ------------------------------------------------------------
    // indexed port cycles
    // ------------------------------------------------------------
    initial host_req = '0;

    task automatic put(input logic sel, input logic [7:0] data);
        @(posedge clk);
        host_req <= '{sel_data: sel, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge clk);
        host_req.wr <= 1'b0;
        // idle data is inverted so a stale byte can never pass as live
        host_req.wdata <= ~data;
    endtask : put

    task automatic get(input logic sel, output logic [7:0] data, output logic ok);
        // call straight after a rising edge; the read is taken at the next one
        ok = 1'b0;
        data = 8'h00;
        host_req.sel_data <= sel;
        host_req.rd <= 1'b1;
        @(posedge clk);
        host_req.rd <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(negedge clk);
            if (host_rvalid === 1'b1)
            begin
                data = host_rdata;
                ok = 1'b1;
            end
        end
    endtask : get
endmodule : daoc_host_model

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import daoc_pkg::*;

    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    daoc_host_req_t host_req;
    logic [7:0] host_rdata;
    logic host_rvalid;
    daoc_mem_ctl_t mem_ctl = '0;
    logic [15:0] start_address_low = 16'h0000;
    logic [18:0] installed_mask = 19'h7ffff;
    logic frame_load = 1'b0;
    logic char_advance = 1'b0;
    logic [1:0] overlay_mode_select = 2'h0;
    logic fcv_n = 1'b1;
    logic crtc_blank = 1'b0;
    logic [18:0] character_address;
    logic [8:0] dram_address;
    logic overlay_active;
    logic ext_dac_enable;
    logic show_live_video;
    logic win_out;
    logic win_oe_n;
    daoc_regs_t regs_out;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'h6ef6;
    logic [63:0] r;
    logic tim;
    logic [7:0] m_edc = RST_EXT_DISPLAY_CONTROL;
    logic [7:0] m_ovm = RST_VIDEO_OVERLAY_MODE;
    logic [7:0] m_lcd = RST_LCD_SHADING_CONTROL;
    logic [18:0] m_cnt = 19'h00000;
    logic [7:0] m_idx = RST_INDEX;
    logic [18:0] a_edc [4] = '{19'h0d, 19'h0b, 19'h0f, 19'h0f};
    logic [18:0] a_low [4] = '{19'hffff, 19'h1234, 19'hffff, 19'hffff};
    logic [18:0] a_msk [4] = '{19'h7ffff, 19'h7ffff, 19'h7ffff, 19'h3ffff};

    initial
    begin
        forever #25 clk = ~clk;
    end

    daoc_host_model i_daoc_host_model (.clk(clk), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid));

    daoc_regs i_daoc_regs (.clk(clk), .rstn(rstn), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .mem_ctl(mem_ctl),
        .start_address_low(start_address_low), .installed_mask(installed_mask),
        .frame_load(frame_load), .char_advance(char_advance),
        .overlay_mode_select(overlay_mode_select),
        .feature_connector_video_input_n(fcv_n), .crtc_blank(crtc_blank),
        .character_address(character_address), .dram_address(dram_address),
        .overlay_active(overlay_active), .ext_dac_enable(ext_dac_enable),
        .show_live_video(show_live_video), .overlay_window_output(win_out),
        .overlay_window_output_oe_n(win_oe_n), .regs_out(regs_out));

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic stop_test();
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ------------------------------------------------------------
    // model and bus helpers
    // ------------------------------------------------------------
    function automatic logic [18:0] m_mask();
        return m_edc[1] ? installed_mask : 19'h0ffff;
    endfunction : m_mask

    function automatic logic [8:0] m_dram();
        logic [6:0] sum;
        sum = {2'b00, mem_ctl.host_bus_address} + (mem_ctl.offset_sel ?
            mem_ctl.graphics_offset_one : mem_ctl.graphics_offset_zero);
        if (m_edc[1] && mem_ctl.dword_mode)
            return {sum, m_cnt[15:14]};
        if (m_edc[1] && mem_ctl.chain4)
            return {sum, sum[5], sum[4]};
        return mem_ctl.std_dram_address;
    endfunction : m_dram

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] data);
        i_daoc_host_model.put(1'b0, idx);
        i_daoc_host_model.put(1'b1, data);
        m_idx = idx;
        if (idx == IDX_EXT_DISPLAY_CONTROL)
            m_edc = data;
        if (idx == IDX_VIDEO_OVERLAY_MODE)
            m_ovm = data & 8'h46;
        if (idx == IDX_LCD_SHADING_CONTROL)
            m_lcd = data;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] idx);
        logic [7:0] d;
        logic ok;
        logic [7:0] e;
        e = (idx == IDX_EXT_DISPLAY_CONTROL) ? m_edc : (idx == IDX_VIDEO_OVERLAY_MODE) ?
            m_ovm : (idx == IDX_LCD_SHADING_CONTROL) ? m_lcd : 8'h00;
        // a sticky index lets the read follow a data write back to back
        if (idx != m_idx)
            i_daoc_host_model.put(1'b0, idx);
        m_idx = idx;
        i_daoc_host_model.get(1'b1, d, ok);
        if (!ok)
        begin
            n_mismatch++;
            stop_test();
        end
        check(d, e);
    endtask : rd_reg

    task automatic do_load();
        @(posedge clk);
        frame_load <= 1'b1;
        @(posedge clk);
        frame_load <= 1'b0;
        m_cnt = {m_edc[3:2], m_edc[0], start_address_low} & m_mask();
        @(negedge clk);
        check(character_address, m_cnt);
    endtask : do_load

    task automatic do_adv();
        @(posedge clk);
        char_advance <= 1'b1;
        @(posedge clk);
        char_advance <= 1'b0;
        m_cnt = (m_cnt + 19'h1) & m_mask();
        @(negedge clk);
        check(character_address, m_cnt);
    endtask : do_adv

    initial
    begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check(regs_out, {m_edc, m_ovm, m_lcd});
        check(win_oe_n, 1'b1);
        rd_reg(IDX_VIDEO_OVERLAY_MODE);
        rd_reg(IDX_LCD_SHADING_CONTROL);
        wr_reg(IDX_VIDEO_OVERLAY_MODE, 8'hff);
        rd_reg(IDX_VIDEO_OVERLAY_MODE);
        wr_reg(IDX_VIDEO_OVERLAY_MODE, 8'h00);
        rd_reg(IDX_VIDEO_OVERLAY_MODE);
        wr_reg(IDX_LCD_SHADING_CONTROL, 8'ha5);
        rd_reg(IDX_LCD_SHADING_CONTROL);
        wr_reg(IDX_LCD_SHADING_CONTROL, 8'h5a);
        rd_reg(IDX_LCD_SHADING_CONTROL);
        wr_reg(8'h7f, 8'h33);
        rd_reg(8'h7f);
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(IDX_EXT_DISPLAY_CONTROL, a_edc[k][7:0]);
            start_address_low <= a_low[k][15:0];
            installed_mask <= a_msk[k];
            do_load();
            do_adv();
        end
        installed_mask <= 19'h7ffff;
        for (int i = 0; i < 48; i++)
        begin
            if (i % 8 == 0)
                wr_reg(IDX_EXT_DISPLAY_CONTROL, {6'h00, i[3], 1'b0});
            @(posedge clk);
            r = {$random(seed), $random(seed)};
            start_address_low <= r[50:35];
            mem_ctl <= r[30:0];
            do_load();
            @(negedge clk);
            check(dram_address, m_dram());
        end
        for (int v = 0; v < 8; v++)
            for (int s = 0; s < 4; s++)
                for (int b = 0; b < 2; b++)
                begin
                    wr_reg(IDX_VIDEO_OVERLAY_MODE, {1'b0, v[2], 3'b000, v[1:0], 1'b0});
                    wr_reg(IDX_EXT_DISPLAY_CONTROL, {2'b00, b[0], 5'h00});
                    @(posedge clk);
                    r = {$random(seed), $random(seed)};
                    overlay_mode_select <= s[1:0];
                    fcv_n <= r[0];
                    crtc_blank <= r[32];
                    repeat (3) @(posedge clk);
                    @(negedge clk);
                    tim = (!v[2] && s == 1) ? !fcv_n :
                        (v[2] && s == 2) ? (b[0] & crtc_blank) : 1'b0;
                    check(regs_out, {m_edc, m_ovm, m_lcd});
                    check(win_oe_n, !b[0]);
                    if (b[0])
                        check(win_out, crtc_blank);
                    check(overlay_active, tim);
                    check(ext_dac_enable, !v[1]);
                    check(show_live_video, !v[1] & (tim ^ v[0]));
                end
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        m_edc = RST_EXT_DISPLAY_CONTROL;
        m_ovm = RST_VIDEO_OVERLAY_MODE;
        m_lcd = RST_LCD_SHADING_CONTROL;
        m_idx = RST_INDEX;
        @(negedge clk);
        check(regs_out, {m_edc, m_ovm, m_lcd});
        stop_test();
    end
endmodule : testbench

`default_nettype wire
